// *** logic/cmx_decode.sv ***
// Purpose: decode and issue control for the compact 16-bit instruction set
// Assumes: fetch presents one halfword a cycle with its address
// Notes:   execute takes every issued instruction; no back-pressure there
`timescale 1ns/10ps
module cmx_decode
	import cmx_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            rst,
	input  wire logic            fetch_valid,
	input  wire logic [HW_W-1:0] fetch_hw,
	input  wire logic [PC_W-1:0] fetch_pc,
	output logic                 fetch_ready,
	input  wire logic            br_taken,
	input  wire logic            mdu_busy,
	output logic                 iss_valid,
	output logic                 iss_cancel,
	output logic [HW_W-1:0]      iss_instr,
	output logic                 iss_ext,
	output logic [15:0]          iss_imm,
	output logic                 iss_imm_signed,
	output logic [5:0]           iss_shamt,
	output logic                 iss_pc_rel,
	output logic                 iss_branch,
	output logic                 iss_jump,
	output logic                 iss_in_slot,
	output logic [PC_W-1:0]      exception_return_pc
);
	// ==========================================
	// state
	cmx_phase_e      phase_q;
	logic [10:0]     pfx_q;
	logic [PC_W-1:0] pfx_pc_q;
	logic [HW_W-1:0] jal_hw_q;
	logic [PC_W-1:0] jal_pc_q;
	logic            slot_q;
	logic [PC_W-1:0] slot_pc_q;
	logic            cancel_q;
	logic [1:0]      ld_cnt_q;
	logic [2:0]      ld_dst_q;

	// ==========================================
	// decode of the present halfword
	logic [4:0]      op;
	logic [HW_W-1:0] fin;
	logic [4:0]      fop;
	logic [4:0]      f5;
	logic [2:0]      f8;
	logic [2:0]      rx;
	logic [2:0]      ry;
	logic            head_hw;
	logic            final_hw;
	logic            ld_haz;
	logic            mdu_haz;
	logic            stall;
	logic            done;
	logic            kill;
	logic            go;
	logic            is_jr;
	logic            is_jal;
	logic            is_branch;
	logic            is_pc_rel;
	logic            ld_ok;
	logic [2:0]      ld_dst;
	logic [PC_W-1:0] base_pc;

	cmx_imm_if ifc ();

	cmx_imm_widen u_widen (
		.bus (ifc.widen)
	);

	assign op  = cmx_op(fetch_hw);
	// a jump pair issues under its first halfword
	assign fin = (phase_q == PH_JAL) ? jal_hw_q : fetch_hw;
	assign fop = cmx_op(fin);
	assign f5  = fin[4:0];
	assign f8  = fin[10:8];
	assign rx  = cmx_rx(fin);
	assign ry  = cmx_ry(fin);

	// ==========================================
	// load destination of an instruction
	function automatic logic [3:0] load_dst(input logic [HW_W-1:0] h);
		logic [4:0] o;
		o = cmx_op(h);
		unique case (o)
			OP_LB, OP_LH, OP_LW, OP_LBU, OP_LHU, OP_LWU, OP_LD: return {1'b1, cmx_ry(h)};
			OP_LWPC, OP_LWSP: return {1'b1, cmx_rx(h)};
			OP_I64: return {(h[10:8] == F64_LDSP || h[10:8] == F64_LDPC), cmx_ry(h)};
			default: return 4'h0;
		endcase
	endfunction

	assign {ld_ok, ld_dst} = load_dst(fin);

	// ==========================================
	// classes of the instruction about to issue
	assign is_jr     = (fop == OP_RR) && (f5 == FN_JR) && (ry <= JR_RY_MAX);
	assign is_jal    = (phase_q == PH_JAL);
	assign is_branch = (fop == OP_B) || (fop == OP_BEQZ) || (fop == OP_BNEZ)
		|| ((fop == OP_I8) && (f8 == F8_BTEQZ || f8 == F8_BTNEZ));
	assign is_pc_rel = (fop == OP_ADDIUPC) || (fop == OP_LWPC)
		|| ((fop == OP_I64) && (f8 == F64_LDPC || f8 == F64_DAPC));

	// ==========================================
	// hazards and the fetch handshake
	// prefix and jump heads carry no operands, so they never wait
	assign head_hw  = (phase_q == PH_FIRST) && (op == OP_EXT || op == OP_JAL);
	assign final_hw = fetch_valid && !head_hw;
	assign ld_haz   = (ld_cnt_q != 2'h0) && !is_jal && ((rx == ld_dst_q) || (ry == ld_dst_q));
	assign mdu_haz  = mdu_busy && (fop == OP_RR) && (f5 == FN_MFHI || f5 == FN_MFLO);
	assign stall    = final_hw && (ld_haz || mdu_haz);
	assign fetch_ready = !stall;
	assign done     = final_hw && !stall;
	// a branch resolves while its successor is being decoded
	assign kill     = br_taken || cancel_q;
	assign go       = done && !kill;

	// ==========================================
	// base address selection, also the exception return address
	always_comb begin
		if (phase_q == PH_EXT)
			base_pc = pfx_pc_q;
		else if (phase_q == PH_JAL)
			base_pc = jal_pc_q;
		else if (slot_q)
			base_pc = slot_pc_q;
		else
			base_pc = fetch_pc;
	end

	// ==========================================
	// immediate widener hookup
	assign ifc.instr = fin;
	assign ifc.ext   = (phase_q == PH_EXT);
	assign ifc.pfx   = pfx_q;

	// ==========================================
	// halfword phase
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_q <= PH_FIRST;
		end else if (fetch_valid && fetch_ready) begin
			unique case (phase_q)
				PH_FIRST: begin
					if (op == OP_EXT)
						phase_q <= PH_EXT;
					else if (op == OP_JAL)
						phase_q <= PH_JAL;
				end
				PH_EXT:   phase_q <= PH_FIRST;
				PH_JAL:   phase_q <= PH_FIRST;
			endcase
		end
	end

	// ==========================================
	// prefix holding; any alignment of the pair is fine
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pfx_q    <= 11'h000;
			pfx_pc_q <= '0;
		end else if (fetch_valid && phase_q == PH_FIRST && op == OP_EXT) begin
			pfx_q    <= fetch_hw[10:0];
			pfx_pc_q <= fetch_pc;
		end
	end

	// ==========================================
	// first half of a 32-bit jump
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			jal_hw_q <= 16'h0000;
			jal_pc_q <= '0;
		end else if (fetch_valid && phase_q == PH_FIRST && op == OP_JAL) begin
			jal_hw_q <= fetch_hw;
			jal_pc_q <= fetch_pc;
		end
	end

	// ==========================================
	// jump delay slot; a kill during the slot still cancels the slot itself
	// a prefixed pair in the slot gets no protection here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slot_q    <= 1'b0;
			slot_pc_q <= '0;
		end else if (go && (is_jr || is_jal)) begin
			slot_q    <= 1'b1;
			slot_pc_q <= base_pc;
		end else if (done && phase_q != PH_EXT) begin
			slot_q    <= 1'b0;
		end
	end

	// ==========================================
	// pending cancel, for a successor not yet complete
	always_ff @(posedge sys_clk) begin
		if (rst)
			cancel_q <= 1'b0;
		else
			cancel_q <= kill && !done;
	end

	// ==========================================
	// load interlock window
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ld_cnt_q <= 2'h0;
			ld_dst_q <= 3'h0;
		end else if (go && ld_ok) begin
			ld_cnt_q <= LD_STALL_CYC;
			ld_dst_q <= ld_dst;
		end else if (ld_cnt_q != 2'h0) begin
			ld_cnt_q <= ld_cnt_q - 2'h1;
		end
	end

	// ==========================================
	// issue strobes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			iss_valid  <= 1'b0;
			iss_cancel <= 1'b0;
		end else begin
			iss_valid  <= go;
			iss_cancel <= done && kill;
		end
	end

	// ==========================================
	// issue payload, held between completions
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			iss_instr           <= 16'h0000;
			iss_ext             <= 1'b0;
			iss_imm             <= 16'h0000;
			iss_imm_signed      <= 1'b0;
			iss_shamt           <= 6'h00;
			iss_pc_rel          <= 1'b0;
			iss_branch          <= 1'b0;
			iss_jump            <= 1'b0;
			iss_in_slot         <= 1'b0;
			exception_return_pc <= '0;
		end else if (done) begin
			iss_instr           <= fin;
			iss_ext             <= (phase_q == PH_EXT);
			// the jump pair hands its second halfword on as target bits
			iss_imm             <= is_jal ? fetch_hw : ifc.imm;
			iss_imm_signed      <= is_jal ? 1'b0 : ifc.imm_signed;
			iss_shamt           <= ifc.shamt;
			iss_pc_rel          <= is_pc_rel;
			iss_branch          <= is_branch;
			iss_jump            <= is_jr || is_jal;
			iss_in_slot         <= slot_q;
			exception_return_pc <= base_pc;
		end
	end
endmodule

// *** logic/cmx_pkg.sv ***
// Purpose: shared constants and helpers for the compact-set decoder
// Assumes: 16-bit halfwords, 64-bit program counter
// Notes:   opcodes are the major field, bits 15..11 of a halfword
package cmx_pkg;
	// ==========================================
	// widths and field positions
	localparam int HW_W   = 16;
	localparam int PC_W   = 64;
	localparam int OP_MSB = 15;
	localparam int OP_LSB = 11;
	localparam int RX_MSB = 10;
	localparam int RX_LSB = 8;
	localparam int RY_MSB = 7;
	localparam int RY_LSB = 5;
	// ==========================================
	// major opcodes
	localparam logic [4:0] OP_ADDIUSP = 5'h00;
	localparam logic [4:0] OP_ADDIUPC = 5'h01;
	localparam logic [4:0] OP_B       = 5'h02;
	localparam logic [4:0] OP_JAL     = 5'h03;
	localparam logic [4:0] OP_BEQZ    = 5'h04;
	localparam logic [4:0] OP_BNEZ    = 5'h05;
	localparam logic [4:0] OP_SHIFT   = 5'h06;
	localparam logic [4:0] OP_LD      = 5'h07;
	localparam logic [4:0] OP_RRIA    = 5'h08;
	localparam logic [4:0] OP_ADDIU8  = 5'h09;
	localparam logic [4:0] OP_I8      = 5'h0C;
	localparam logic [4:0] OP_LI      = 5'h0D;
	localparam logic [4:0] OP_CMPI    = 5'h0E;
	localparam logic [4:0] OP_SD      = 5'h0F;
	localparam logic [4:0] OP_LB      = 5'h10;
	localparam logic [4:0] OP_LH      = 5'h11;
	localparam logic [4:0] OP_LWSP    = 5'h12;
	localparam logic [4:0] OP_LW      = 5'h13;
	localparam logic [4:0] OP_LBU     = 5'h14;
	localparam logic [4:0] OP_LHU     = 5'h15;
	localparam logic [4:0] OP_LWPC    = 5'h16;
	localparam logic [4:0] OP_LWU     = 5'h17;
	localparam logic [4:0] OP_SB      = 5'h18;
	localparam logic [4:0] OP_SH      = 5'h19;
	localparam logic [4:0] OP_SWSP    = 5'h1A;
	localparam logic [4:0] OP_SW      = 5'h1B;
	localparam logic [4:0] OP_RR      = 5'h1D;
	localparam logic [4:0] OP_EXT     = 5'h1E;
	localparam logic [4:0] OP_I64     = 5'h1F;
	// ==========================================
	// minor codes
	localparam logic [4:0] FN_JR     = 5'h00;
	localparam logic [4:0] FN_DSRL   = 5'h08;
	localparam logic [4:0] FN_MFHI   = 5'h10;
	localparam logic [4:0] FN_MFLO   = 5'h12;
	localparam logic [4:0] FN_DSRA   = 5'h13;
	localparam logic [2:0] JR_RY_MAX = 3'h2;
	localparam logic [2:0] F8_BTEQZ  = 3'h0;
	localparam logic [2:0] F8_BTNEZ  = 3'h1;
	localparam logic [2:0] F64_LDSP  = 3'h0;
	localparam logic [2:0] F64_LDPC  = 3'h4;
	localparam logic [2:0] F64_DAPC  = 3'h6;
	localparam logic [1:0] SH_DSLL   = 2'h1;
	// ==========================================
	// counts
	localparam logic [5:0] SHAMT_ZERO_AS = 6'h08;
	localparam logic [1:0] LD_STALL_CYC  = 2'h1;
	typedef enum logic [1:0] {PH_FIRST, PH_EXT, PH_JAL} cmx_phase_e;
	// ==========================================
	// field helpers
	function automatic logic [4:0] cmx_op(input logic [HW_W-1:0] h);
		return h[OP_MSB:OP_LSB];
	endfunction
	function automatic logic [2:0] cmx_rx(input logic [HW_W-1:0] h);
		return h[RX_MSB:RX_LSB];
	endfunction
	function automatic logic [2:0] cmx_ry(input logic [HW_W-1:0] h);
		return h[RY_MSB:RY_LSB];
	endfunction
endpackage

// *** logic/cmx_imm_if.sv ***
// Purpose: carries one instruction to the immediate widener and back
// Assumes: purely combinational exchange
// Notes:   pfx holds the eleven immediate bits of a held prefix
`timescale 1ns/10ps
interface cmx_imm_if;
	logic [15:0] instr;
	logic        ext;
	logic [10:0] pfx;
	logic [15:0] imm;
	logic        imm_signed;
	logic [5:0]  shamt;
	modport widen (input instr, input ext, input pfx, output imm, output imm_signed, output shamt);
	modport dec   (output instr, output ext, output pfx, input imm, input imm_signed, input shamt);
endinterface

// *** logic/cmx_imm_widen.sv ***
// Purpose: forms the widened immediate and shift count of one instruction
// Assumes: prefix bits already held by the decoder
// Notes:   scaling of unextended offsets is applied here
`timescale 1ns/10ps
module cmx_imm_widen
	import cmx_pkg::*;
(
	cmx_imm_if.widen bus
);
	logic [4:0]  op;
	logic [15:0] full16;
	logic [15:0] in;
	assign op     = cmx_op(bus.instr);
	assign in     = bus.instr;
	assign full16 = {bus.pfx[4:0], bus.pfx[10:5], in[4:0]};

	// ==========================================
	// widening per major opcode
	always_comb begin
		bus.imm        = 16'h0000;
		bus.imm_signed = 1'b0;
		bus.shamt      = 6'h00;
		if (bus.ext) begin
			unique case (op)
				OP_SHIFT: begin
					// no zero-means-eight remap once prefixed
					bus.shamt = (in[1:0] == SH_DSLL) ? {bus.pfx[5], bus.pfx[10:6]}
						: {1'b0, bus.pfx[10:6]};
				end
				OP_RR: bus.shamt = {bus.pfx[5], bus.pfx[10:6]};
				OP_RRIA: begin
					bus.imm        = {bus.pfx[3], bus.pfx[3:0], bus.pfx[10:5], in[4:0]};
					bus.imm_signed = 1'b1;
				end
				default: begin
					bus.imm        = full16;
					bus.imm_signed = !(op == OP_LI || op == OP_CMPI);
				end
			endcase
		end else begin
			unique case (op)
				OP_SHIFT: bus.shamt = (in[4:2] == 3'h0) ? SHAMT_ZERO_AS : {3'h0, in[4:2]};
				OP_RR:    bus.shamt = (in[10:8] == 3'h0) ? SHAMT_ZERO_AS : {3'h0, in[10:8]};
				OP_RRIA: begin
					bus.imm        = {{12{in[3]}}, in[3:0]};
					bus.imm_signed = 1'b1;
				end
				OP_LB, OP_LBU, OP_SB: bus.imm = {11'h000, in[4:0]};
				OP_LH, OP_LHU, OP_SH: bus.imm = {10'h000, in[4:0], 1'b0};
				OP_LW, OP_LWU, OP_SW: bus.imm = {9'h000, in[4:0], 2'h0};
				OP_LD, OP_SD:         bus.imm = {8'h00, in[4:0], 3'h0};
				OP_LWPC, OP_LWSP, OP_SWSP, OP_ADDIUPC, OP_ADDIUSP: bus.imm = {6'h00, in[7:0], 2'h0};
				OP_LI, OP_CMPI:       bus.imm = {8'h00, in[7:0]};
				OP_B: begin
					bus.imm        = {{5{in[10]}}, in[10:0]};
					bus.imm_signed = 1'b1;
				end
				OP_I64: begin
					if (in[10:8] == F64_LDPC)
						bus.imm = {8'h00, in[4:0], 3'h0};
					else
						bus.imm = {8'h00, in[7:0]};
				end
				default: begin
					bus.imm        = {{8{in[7]}}, in[7:0]};
					bus.imm_signed = 1'b1;
				end
			endcase
		end
	end
endmodule

// *** verification/cmx_decode_sva.sv ***
// Purpose: port-level checks for the compact-set decoder
// Assumes: bound onto cmx_decode, one clock domain
// Notes:   a head is a prefix or the first half of a 32-bit jump
`timescale 1ns/10ps
module cmx_decode_sva
	import cmx_pkg::*;
(
	input wire logic            sys_clk,
	input wire logic            rst,
	input wire logic            fetch_valid,
	input wire logic [HW_W-1:0] fetch_hw,
	input wire logic [PC_W-1:0] fetch_pc,
	input wire logic            fetch_ready,
	input wire logic            br_taken,
	input wire logic            mdu_busy,
	input wire logic            iss_valid,
	input wire logic            iss_cancel,
	input wire logic [HW_W-1:0] iss_instr,
	input wire logic            iss_ext,
	input wire logic [15:0]     iss_imm,
	input wire logic [5:0]      iss_shamt,
	input wire logic            iss_pc_rel,
	input wire logic            iss_jump,
	input wire logic            iss_in_slot,
	input wire logic [PC_W-1:0] exception_return_pc
);
	// ==========================================
	// helper state
	logic            take;
	logic            done;
	logic            head_in;
	logic            head_q;
	logic            pend_q;
	logic            slot_q;
	logic [PC_W-1:0] jpc_q;
	logic [4:0]      op;
	assign op = cmx_op(fetch_hw);
	assign take = fetch_valid && fetch_ready;
	assign done = iss_valid || iss_cancel;
	assign head_in = !head_q && (op == OP_EXT || op == OP_JAL);
	// a head is only a head when it does not itself finish a pair
	always_ff @(posedge sys_clk) begin
		if (rst) head_q <= 1'b0;
		else if (take) head_q <= head_in;
	end
	// set wins: a cancel stays pending until one completion uses it
	always_ff @(posedge sys_clk) begin
		if (rst) pend_q <= 1'b0;
		else pend_q <= br_taken || (pend_q && !done);
	end
	// next completion after a jump issue is its slot
	always_ff @(posedge sys_clk) begin
		if (rst) slot_q <= 1'b0;
		else if (iss_valid && iss_jump) slot_q <= 1'b1;
		else if (done) slot_q <= 1'b0;
	end
	// jump address as the jump itself reported it
	always_ff @(posedge sys_clk) begin
		if (iss_valid && iss_jump) jpc_q <= exception_return_pc;
	end
	// ==========================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_head_silent: assert property (take && head_in |=> !done)
		else $error("head halfword completed alone");
	a_final_issue: assert property (take && !head_in |=> done)
		else $error("final halfword did not complete next cycle");
	a_own_base: assert property (take && !head_in && !head_q |=> iss_in_slot || exception_return_pc == $past(fetch_pc))
		else $error("plain base address wrong");
	a_prefix_base: assert property (take && head_in && op == OP_EXT ##1 take |=> iss_ext && exception_return_pc == $past(fetch_pc, 2))
		else $error("prefixed base address wrong");
	a_slot_base: assert property (done && iss_in_slot && iss_pc_rel && !iss_ext |-> exception_return_pc == jpc_q)
		else $error("slot base address wrong");
	a_slot_flag: assert property (done |-> iss_in_slot == slot_q)
		else $error("slot marking wrong");
	a_cancel_next: assert property (done |-> iss_cancel == pend_q)
		else $error("cancel outcome wrong");
	a_load_interlock: assert property (iss_valid && cmx_op(iss_instr) == OP_LW && fetch_valid && !head_in
		&& cmx_rx(fetch_hw) == cmx_ry(iss_instr) |-> !fetch_ready)
		else $error("load hazard not interlocked");
	a_load_once: assert property (!fetch_ready && !mdu_busy ##1 !mdu_busy |-> fetch_ready)
		else $error("interlock longer than one cycle");
	a_mdu_stall: assert property (fetch_valid && !head_q && op == OP_RR && mdu_busy
		&& (fetch_hw[4:0] == FN_MFHI || fetch_hw[4:0] == FN_MFLO) |-> !fetch_ready)
		else $error("product read not stalled");
	a_word_scale: assert property (done && !iss_ext && cmx_op(iss_instr) == OP_LW
		|-> iss_imm == {9'h000, iss_instr[4:0], 2'h0})
		else $error("word offset scaling wrong");
	a_shift_eight: assert property (done && !iss_ext && cmx_op(iss_instr) == OP_SHIFT && iss_instr[4:2] == 3'h0
		|-> iss_shamt == SHAMT_ZERO_AS)
		else $error("zero count not taken as eight");
	// main scenarios seen
	c_prefixed: cover property (done && iss_ext);
	c_cancel: cover property (iss_cancel);
	c_slot_rel: cover property (done && iss_in_slot && iss_pc_rel);
endmodule

bind cmx_decode cmx_decode_sva cmx_decode_sva_inst (
	.sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_hw(fetch_hw),
	.fetch_pc(fetch_pc), .fetch_ready(fetch_ready), .br_taken(br_taken), .mdu_busy(mdu_busy),
	.iss_valid(iss_valid), .iss_cancel(iss_cancel), .iss_instr(iss_instr), .iss_ext(iss_ext),
	.iss_imm(iss_imm), .iss_shamt(iss_shamt), .iss_pc_rel(iss_pc_rel), .iss_jump(iss_jump),
	.iss_in_slot(iss_in_slot), .exception_return_pc(exception_return_pc)
);

// *** verification/cmx_fetch_model.sv ***
// Purpose: instruction fetch stand-in feeding halfwords in program order
// Assumes: bench queues halfwords only after reset
// Notes:   idle bus flips every cycle so stale data never looks valid
`timescale 1ns/10ps
module cmx_fetch_model
	import cmx_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            fetch_ready,
	output logic                 fetch_valid,
	output logic [HW_W-1:0]      fetch_hw,
	output logic [PC_W-1:0]      fetch_pc
);
	logic [HW_W-1:0] hq[$];
	logic [PC_W-1:0] pq[$];
	logic            took;
	// queue keeps a prefix directly before its instruction
	task automatic push(input logic [HW_W-1:0] h, input logic [PC_W-1:0] p);
		hq.push_back(h);
		pq.push_back(p);
	endtask
	initial begin
		fetch_valid = 1'b0;
		fetch_hw = 16'h0000;
		fetch_pc = 64'h0;
		took = 1'b0;
	end
	// remember whether the offer was taken at this edge
	always @(posedge sys_clk) took <= fetch_valid && fetch_ready;
	// offer held until taken, then next halfword back to back
	always @(negedge sys_clk) begin
		if (took) begin
			void'(hq.pop_front());
			void'(pq.pop_front());
		end
		if (hq.size() > 0) begin
			fetch_valid = 1'b1;
			fetch_hw = hq[0];
			fetch_pc = pq[0];
		end else begin
			fetch_valid = 1'b0;
			fetch_hw = ~fetch_hw;
			fetch_pc = ~fetch_pc;
		end
	end
endmodule

// *** verification/tb_compact_isa_extend_and_slot_control.sv ***
// Purpose: self-checking bench for the compact-set decoder
// Assumes: fetch model feeds halfwords, bench drives branch and multiply state
// Notes:   no software-forbidden sequences are generated
`timescale 1ns/10ps
module tb_compact_isa_extend_and_slot_control
	import cmx_pkg::*;
;
	typedef struct packed {
		logic        e;
		logic        ci;
		logic [15:0] p;
		logic [15:0] h;
		logic [15:0] m;
		logic [5:0]  s;
	} cmx_row_s;
	logic            sys_clk, rst, fetch_valid, fetch_ready, br_taken, mdu_busy;
	logic            iss_valid, iss_cancel, iss_ext, iss_imm_signed, iss_pc_rel;
	logic            iss_branch, iss_jump, iss_in_slot;
	logic [HW_W-1:0] fetch_hw, iss_instr;
	logic [PC_W-1:0] fetch_pc, exception_return_pc;
	logic [15:0]     iss_imm;
	logic [5:0]      iss_shamt;
	int              n_errors, compares, gap;
	logic [PC_W-1:0] jp[2] = '{64'h4000, 64'h4010};
	logic [15:0]     dep[2] = '{16'h4A01, 16'h4B01};
	// prefix flag, check imm, prefix, instruction, imm, count
	cmx_row_s        rows[16] = '{
		'{1'h0, 1'h1, 16'h0000, 16'h995F, 16'h007C, 6'h00},
		'{1'h1, 1'h1, 16'hF010, 16'h9940, 16'h8000, 6'h00},
		'{1'h1, 1'h1, 16'hF7EF, 16'h995F, 16'h7FFF, 6'h00},
		'{1'h0, 1'h0, 16'h0000, 16'h3140, 16'h0000, 6'h08},
		'{1'h1, 1'h0, 16'hF7C0, 16'h3140, 16'h0000, 6'h1F},
		'{1'h1, 1'h0, 16'hF000, 16'h3140, 16'h0000, 6'h00},
		'{1'h1, 1'h0, 16'hF7E0, 16'hE848, 16'h0000, 6'h3F},
		'{1'h0, 1'h0, 16'h0000, 16'hE848, 16'h0000, 6'h08},
		'{1'h0, 1'h0, 16'h0000, 16'hEB53, 16'h0000, 6'h03},
		'{1'h1, 1'h0, 16'hF060, 16'h3141, 16'h0000, 6'h21},
		'{1'h1, 1'h1, 16'hF008, 16'h4140, 16'hC000, 6'h00},
		'{1'h1, 1'h1, 16'hF010, 16'h6001, 16'h8001, 6'h00},
		'{1'h0, 1'h1, 16'h0000, 16'h6080, 16'hFF80, 6'h00},
		'{1'h1, 1'h1, 16'hF7FF, 16'h691F, 16'hFFFF, 6'h00},
		'{1'h0, 1'h1, 16'h0000, 16'h0904, 16'h0010, 6'h00},
		'{1'h1, 1'h1, 16'hF000, 16'h0904, 16'h0004, 6'h00}};

	cmx_decode cmx_decode_inst (
		.sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_hw(fetch_hw),
		.fetch_pc(fetch_pc), .fetch_ready(fetch_ready), .br_taken(br_taken), .mdu_busy(mdu_busy),
		.iss_valid(iss_valid), .iss_cancel(iss_cancel), .iss_instr(iss_instr), .iss_ext(iss_ext),
		.iss_imm(iss_imm), .iss_imm_signed(iss_imm_signed), .iss_shamt(iss_shamt),
		.iss_pc_rel(iss_pc_rel), .iss_branch(iss_branch), .iss_jump(iss_jump),
		.iss_in_slot(iss_in_slot), .exception_return_pc(exception_return_pc));
	cmx_fetch_model cmx_fetch_model_inst (
		.sys_clk(sys_clk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
		.fetch_hw(fetch_hw), .fetch_pc(fetch_pc));

	// ==========================================
	// helpers
	task automatic wrap_up();
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic put(input logic [15:0] h, input logic [PC_W-1:0] p);
		cmx_fetch_model_inst.push(h, p);
	endtask
	// bounded wait, counts edges until the next completion
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (iss_valid !== 1'b1 && iss_cancel !== 1'b1 && n < 40);
		if (n >= 40) check(1'b0, "no completion");
	endtask

	// ==========================================
	// clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// whole run is well under a hundred cycles; this is ample
	initial begin
		#50000;
		n_errors++;
		wrap_up();
	end

	// ==========================================
	// main sequence
	initial begin
		rst = 1'b1;
		br_taken = 1'b0;
		mdu_busy = 1'b0;
		n_errors = 0;
		compares = 0;
		repeat (3) @(posedge sys_clk);
		#1;
		check(iss_valid === 1'h0 && iss_cancel === 1'h0 && fetch_ready === 1'h1, "reset state");
		@(negedge sys_clk) rst = 1'b0;
		// table of widening cases; prefixed pairs straddle a word boundary
		for (int i = 0; i < 16; i++) begin
			if (rows[i].e) put(rows[i].p, 64'h1002 + 64'(i * 8));
			put(rows[i].h, 64'h1004 + 64'(i * 8));
			wait_done(gap);
			check(iss_valid === 1'h1 && iss_ext === rows[i].e && iss_shamt === rows[i].s
				&& (!rows[i].ci || iss_imm === rows[i].m), "widened value");
			check(exception_return_pc === (rows[i].e ? 64'h1002 : 64'h1004) + 64'(i * 8), "base address");
			check(iss_pc_rel === (rows[i].h[15:11] == OP_ADDIUPC), "pc-relative flag");
			check(!(rows[i].e && rows[i].ci) || iss_imm_signed === (rows[i].h[15:11] != OP_LI), "imm sign");
		end
		// dependent read waits one cycle, independent one does not
		foreach (dep[j]) begin
			put(16'h995F, 64'h2000);
			put(dep[j], 64'h2002);
			wait_done(gap);
			wait_done(gap);
			check(gap === 2 - j && iss_valid === 1'h1, "load interlock");
		end
		// taken branch cancels a prefixed successor as one unit
		put(16'h2904, 64'h3000);
		put(16'hF7FF, 64'h3002);
		put(16'h691F, 64'h3004);
		put(16'h4B02, 64'h3006);
		wait_done(gap);
		check(iss_valid === 1'h1 && iss_branch === 1'h1, "branch issue");
		@(negedge sys_clk) br_taken = 1'b1;
		@(negedge sys_clk) br_taken = 1'b0;
		wait_done(gap);
		check(iss_cancel === 1'h1 && iss_valid === 1'h0 && iss_ext === 1'h1, "successor cancel");
		wait_done(gap);
		check(iss_valid === 1'h1 && iss_instr === 16'h4B02, "after cancel");
		// register jump then 32-bit jump, each with a pc-relative slot
		put(16'hE900, 64'h4000);
		put(16'h0904, 64'h4002);
		put(16'h1800, 64'h4010);
		put(16'h0000, 64'h4012);
		put(16'h0904, 64'h4014);
		foreach (jp[j]) begin
			wait_done(gap);
			check(iss_valid === 1'h1 && iss_jump === 1'h1 && iss_in_slot === 1'h0, "jump issue");
			wait_done(gap);
			check(gap === 1 && iss_in_slot === 1'h1 && exception_return_pc === jp[j], "slot base");
			check(iss_pc_rel === 1'h1 && iss_ext === 1'h0, "slot pc-relative");
		end
		// product read held off while the multiplier is busy
		@(negedge sys_clk) mdu_busy = 1'b1;
		// the product read is the last instruction, so nothing writes the product registers after it
		put(16'hE910, 64'h5000);
		repeat (6) @(negedge sys_clk);
		check(fetch_ready === 1'h0 && iss_valid === 1'h0, "product stall");
		mdu_busy = 1'b0;
		wait_done(gap);
		check(gap === 1 && iss_valid === 1'h1, "product read");
		wrap_up();
	end
endmodule
